// ### rtl/rbc_pkg.sv
// Constants, field layout and state types of the baseband control registers
package rbc_pkg;
  // ==========================================================
  // Register indexes (byte address is four times the index)
  localparam logic [9:0] IDX_SLEEP = 10'h035;
  localparam logic [9:0] IDX_RFMODE = 10'h036;
  localparam logic [9:0] IDX_CIPHER = 10'h037;
  localparam logic [9:0] IDX_RATE = 10'h038;
  localparam logic [9:0] IDX_POLAR = 10'h039;
  localparam logic [9:0] IDX_ASSESS = 10'h03A;
  localparam logic [9:0] IDX_PREAMBLE = 10'h03B;
  localparam logic [9:0] IDX_CSENSE = 10'h03C;
  localparam logic [9:0] IDX_STRENGTH = 10'h03E;
  localparam logic [9:0] IDX_ENERGY = 10'h03F;
  localparam logic [9:0] IDX_TICKSRC = 10'h207;
  localparam logic [9:0] IDX_TICKDIV = 10'h210;
  // ==========================================================
  // Field positions
  localparam int SLEEP_GO_BIT = 7;
  localparam int WAKE_HI_LSB = 3;
  localparam int RF_RST_BIT = 2;
  localparam int DEC_BIT = 7;
  localparam int ENC_BIT = 6;
  localparam int SUITE2_LSB = 3;
  localparam int SUITE1_LSB = 0;
  localparam int TURBO_BIT = 0;
  localparam int INV_BIT = 2;
  localparam int MODE_LSB = 6;
  localparam int ACST_LSB = 2;
  localparam int PVAL_LSB = 4;
  localparam int PDET_LSB = 1;
  localparam int CSL_LSB = 5;
  localparam int PCNT_LSB = 2;
  localparam int SS_BIT = 7;
  localparam int PP_BIT = 6;
  localparam int RDY_BIT = 0;
  localparam int SRC_LSB = 6;
  // ==========================================================
  // Reset values and encodings
  localparam logic [8:0] WAKE_RST = 9'h000;
  localparam logic [2:0] SUITE_NONE = 3'h0;
  localparam logic [1:0] MODE_RST = 2'h1;
  localparam logic [3:0] ACST_RST = 4'h2;
  localparam logic [3:0] PVAL_RST = 4'hD;
  localparam logic [2:0] PDET_RST = 3'h4;
  localparam logic [2:0] CSL_RST = 3'h4;
  localparam logic [2:0] PCNT_RST = 3'h7;
  localparam logic [7:0] ENERGY_RST = 8'h00;
  localparam logic [1:0] SRC_RST = 2'h0;
  localparam logic [4:0] DIV_RST = 5'h00;
  localparam logic [1:0] SRC_INT = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] MODE_ENERGY = 2'h2;
  localparam logic [1:0] MODE_CARRIER = 2'h1;
  localparam logic [1:0] MODE_BOTH = 2'h3;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 125_000_000;
  localparam int INT_HZ = 100_000;
  localparam int EXT_HZ = 32_000;
  localparam logic [11:0] INT_CYC = 12'(CLK_HZ / INT_HZ);
  localparam logic [11:0] EXT_CYC = 12'(CLK_HZ / EXT_HZ);
  typedef enum logic [1:0] {RBC_AWAKE, RBC_ASLEEP, RBC_WARMUP} rbc_sleep_t;
endpackage : rbc_pkg

// ### rtl/rbc_regs.sv
// Baseband control register bank with APB slave, sleep timing and channel assessment
//
// Register access over APB was chosen for this implementation.
module rbc_regs
  import rbc_pkg::*;
(
  input wire logic clock_i,              // 125 MHz clock
  input wire logic nrst_i,               // Async reset, active low
  input wire logic psel_i,               // APB select
  input wire logic penable_i,            // APB enable
  input wire logic pwrite_i,             // APB direction
  input wire logic [11:0] paddr_i,       // APB byte address
  input wire logic [31:0] pwdata_i,      // APB write data
  output logic [31:0] prdata_o,          // APB read data
  output logic pready_o,                 // APB ready
  output logic pslverr_o,                // APB error, unmapped
  input wire logic wake_req_i,           // Wake pin, asynchronous
  output logic sleep_o,                  // Device asleep
  output logic osc_enable_o,             // Main oscillator on
  output logic osc_ready_o,              // Oscillator start-up done
  output logic rf_fsm_reset_o,           // RF state machine reset
  output logic decrypt_go_o,             // Decrypt request level
  output logic encrypt_go_o,             // Encrypt request level
  input wire logic cipher_done_i,        // Cipher operation finished
  output logic [2:0] slot1_tx_suite_o,   // Slot one suite
  output logic [2:0] slot2_tx_suite_o,   // Slot two suite
  output logic turbo_o,                  // Turbo rate selected
  input wire logic rx_sign_i,            // Received symbol sign
  output logic rx_sign_o,                // Sign after inversion
  output logic [3:0] preamble_valid_threshold_o,  // Preamble valid level
  output logic [2:0] preamble_detect_threshold_o, // Preamble detect level
  output logic [2:0] carrier_sense_level_o,       // Carrier sense level
  output logic [2:0] preamble_count_threshold_o,  // Preamble count
  output logic [3:0] assess_carrier_threshold_o,  // Assess carrier level
  input wire logic carrier_detect_i,     // Carrier detected
  input wire logic [7:0] strength_level_i, // In-band signal strength
  output logic channel_busy_o,           // Channel busy result
  output logic strength_start_o,         // Single-shot start pulse
  input wire logic strength_done_i,      // Measurement finished
  output logic strength_per_packet_o     // Per-packet measurement on
);

  // ==========================================================
  // Helpers
  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    hit = (a[11:2] == idx);
  endfunction : hit

  // ==========================================================
  // State
  logic [8:0] wake_count_r, wake_count_nxt;
  logic rf_reset_r, rf_reset_nxt;
  logic dec_r, dec_nxt, enc_r, enc_nxt;
  logic [2:0] suite1_r, suite1_nxt, suite2_r, suite2_nxt;
  logic turbo_r, turbo_nxt, invert_r, invert_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [3:0] acst_r, acst_nxt, pval_r, pval_nxt;
  logic [2:0] pdet_r, pdet_nxt, csl_r, csl_nxt, pcnt_r, pcnt_nxt;
  logic ss_r, ss_nxt, pp_r, pp_nxt, ready_r, ready_nxt;
  logic [7:0] energy_r, energy_nxt;
  logic [1:0] src_r, src_nxt;
  logic [4:0] div_r, div_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic err_r, err_nxt;
  logic sign_r, sign_nxt, busy_r, busy_nxt;
  rbc_sleep_t st_r, st_nxt;
  logic [11:0] pre_r, pre_nxt;
  logic [4:0] dcnt_r, dcnt_nxt;
  logic [8:0] wcnt_r, wcnt_nxt;
  logic osc_rdy_r, osc_rdy_nxt;
  logic wake_s1_r, wake_s2_r;
  logic setup, wr, sleep_go, tick;
  logic [7:0] w;
  logic [11:0] period;

  assign setup = psel_i & ~penable_i;
  assign wr = psel_i & penable_i & pwrite_i;
  assign w = pwdata_i[7:0];
  assign pready_o = psel_i & penable_i;
  assign pslverr_o = pready_o & err_r;
  assign prdata_o = rdata_r;

  // ==========================================================
  // Read decode, latched in the setup cycle
  always_comb begin
    rdata_nxt = rdata_r;
    err_nxt = err_r;
    if (setup) begin
      rdata_nxt = '0;
      err_nxt = 1'b0;
      if (hit(paddr_i, IDX_SLEEP)) begin
        rdata_nxt[6:0] = wake_count_r[6:0];
      end else if (hit(paddr_i, IDX_RFMODE)) begin
        rdata_nxt[WAKE_HI_LSB +: 2] = wake_count_r[8:7];
        rdata_nxt[RF_RST_BIT] = rf_reset_r;
      end else if (hit(paddr_i, IDX_CIPHER)) begin
        rdata_nxt[DEC_BIT] = dec_r;
        rdata_nxt[ENC_BIT] = enc_r;
        rdata_nxt[SUITE2_LSB +: 3] = suite2_r;
        rdata_nxt[SUITE1_LSB +: 3] = suite1_r;
      end else if (hit(paddr_i, IDX_RATE)) begin
        rdata_nxt[TURBO_BIT] = turbo_r;
      end else if (hit(paddr_i, IDX_POLAR)) begin
        rdata_nxt[INV_BIT] = invert_r;
      end else if (hit(paddr_i, IDX_ASSESS)) begin
        rdata_nxt[MODE_LSB +: 2] = mode_r;
        rdata_nxt[ACST_LSB +: 4] = acst_r;
      end else if (hit(paddr_i, IDX_PREAMBLE)) begin
        rdata_nxt[PVAL_LSB +: 4] = pval_r;
        rdata_nxt[PDET_LSB +: 3] = pdet_r;
      end else if (hit(paddr_i, IDX_CSENSE)) begin
        rdata_nxt[CSL_LSB +: 3] = csl_r;
        rdata_nxt[PCNT_LSB +: 3] = pcnt_r;
      end else if (hit(paddr_i, IDX_STRENGTH)) begin
        rdata_nxt[PP_BIT] = pp_r;
        rdata_nxt[RDY_BIT] = ready_r;
      end else if (hit(paddr_i, IDX_ENERGY)) begin
        rdata_nxt[7:0] = energy_r;
      end else if (hit(paddr_i, IDX_TICKSRC)) begin
        rdata_nxt[SRC_LSB +: 2] = src_r;
      end else if (hit(paddr_i, IDX_TICKDIV)) begin
        rdata_nxt[4:0] = div_r;
      end else begin
        err_nxt = 1'b1;
      end
    end
  end

  // ==========================================================
  // Register writes and hardware updates
  always_comb begin
    wake_count_nxt = wake_count_r;
    rf_reset_nxt = rf_reset_r;
    dec_nxt = dec_r;
    enc_nxt = enc_r;
    suite1_nxt = suite1_r;
    suite2_nxt = suite2_r;
    turbo_nxt = turbo_r;
    invert_nxt = invert_r;
    mode_nxt = mode_r;
    acst_nxt = acst_r;
    pval_nxt = pval_r;
    pdet_nxt = pdet_r;
    csl_nxt = csl_r;
    pcnt_nxt = pcnt_r;
    pp_nxt = pp_r;
    energy_nxt = energy_r;
    src_nxt = src_r;
    div_nxt = div_r;
    sleep_go = 1'b0;
    // trigger lasts one cycle, then clears itself
    ss_nxt = 1'b0;
    ready_nxt = ready_r;
    if (cipher_done_i) begin
      dec_nxt = 1'b0;
      enc_nxt = 1'b0;
    end
    if (strength_done_i) begin
      ready_nxt = 1'b1;
    end
    if (wr) begin
      if (hit(paddr_i, IDX_SLEEP)) begin
        wake_count_nxt[6:0] = w[6:0];
        sleep_go = w[SLEEP_GO_BIT];
      end else if (hit(paddr_i, IDX_RFMODE)) begin
        wake_count_nxt[8:7] = w[WAKE_HI_LSB +: 2];
        rf_reset_nxt = w[RF_RST_BIT];
      end else if (hit(paddr_i, IDX_CIPHER)) begin
        // set wins over a same-cycle done
        if (w[DEC_BIT]) begin
          dec_nxt = 1'b1;
        end
        // set wins over a same-cycle done
        if (w[ENC_BIT]) begin
          enc_nxt = 1'b1;
        end
        suite2_nxt = w[SUITE2_LSB +: 3];
        suite1_nxt = w[SUITE1_LSB +: 3];
      end else if (hit(paddr_i, IDX_RATE)) begin
        turbo_nxt = w[TURBO_BIT];
      end else if (hit(paddr_i, IDX_POLAR)) begin
        invert_nxt = w[INV_BIT];
      end else if (hit(paddr_i, IDX_ASSESS)) begin
        mode_nxt = w[MODE_LSB +: 2];
        acst_nxt = w[ACST_LSB +: 4];
      end else if (hit(paddr_i, IDX_PREAMBLE)) begin
        pval_nxt = w[PVAL_LSB +: 4];
        pdet_nxt = w[PDET_LSB +: 3];
      end else if (hit(paddr_i, IDX_CSENSE)) begin
        csl_nxt = w[CSL_LSB +: 3];
        pcnt_nxt = w[PCNT_LSB +: 3];
      end else if (hit(paddr_i, IDX_STRENGTH)) begin
        pp_nxt = w[PP_BIT];
        if (w[SS_BIT]) begin
          ss_nxt = 1'b1;
          ready_nxt = 1'b0;
        end
      end else if (hit(paddr_i, IDX_ENERGY)) begin
        energy_nxt = w;
      end else if (hit(paddr_i, IDX_TICKSRC)) begin
        src_nxt = w[SRC_LSB +: 2];
      end else if (hit(paddr_i, IDX_TICKDIV)) begin
        div_nxt = w[4:0];
      end
    end
  end

  // ==========================================================
  // Sleep tick, wake timer and sleep state
  always_comb begin
    period = (src_r == SRC_EXT) ? EXT_CYC : INT_CYC;
    pre_nxt = pre_r;
    dcnt_nxt = dcnt_r;
    wcnt_nxt = wcnt_r;
    st_nxt = st_r;
    osc_rdy_nxt = osc_rdy_r;
    tick = 1'b0;
    if (st_r == RBC_AWAKE) begin
      pre_nxt = '0;
      dcnt_nxt = '0;
    end else if (pre_r >= period - 12'h001) begin
      pre_nxt = '0;
      if (dcnt_r >= div_r) begin
        dcnt_nxt = '0;
        tick = 1'b1;
      end else begin
        dcnt_nxt = dcnt_r + 5'h01;
      end
    end else begin
      pre_nxt = pre_r + 12'h001;
    end
    case (st_r)
      RBC_AWAKE: begin
        if (sleep_go) begin
          st_nxt = RBC_ASLEEP;
          osc_rdy_nxt = 1'b0;
        end
      end
      RBC_ASLEEP: begin
        if (wake_s2_r) begin
          st_nxt = RBC_WARMUP;
          wcnt_nxt = '0;
        end
      end
      RBC_WARMUP: begin
        if (wcnt_r >= wake_count_r) begin
          st_nxt = RBC_AWAKE;
          osc_rdy_nxt = 1'b1;
        end else if (tick) begin
          wcnt_nxt = wcnt_r + 9'h001;
        end
      end
      default: begin
        st_nxt = RBC_AWAKE;
      end
    endcase
  end

  // ==========================================================
  // Datapath outputs
  always_comb begin
    sign_nxt = rx_sign_i ^ invert_r;
    case (mode_r)
      MODE_ENERGY: busy_nxt = strength_level_i > energy_r;
      MODE_CARRIER: busy_nxt = carrier_detect_i;
      MODE_BOTH: busy_nxt = carrier_detect_i & (strength_level_i > energy_r);
      default: busy_nxt = 1'b0;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_count_r <= WAKE_RST;
      rf_reset_r <= 1'b0;
      dec_r <= 1'b0;
      enc_r <= 1'b0;
      suite1_r <= SUITE_NONE;
      suite2_r <= SUITE_NONE;
      turbo_r <= 1'b0;
      invert_r <= 1'b0;
      mode_r <= MODE_RST;
      acst_r <= ACST_RST;
      pval_r <= PVAL_RST;
      pdet_r <= PDET_RST;
      csl_r <= CSL_RST;
      pcnt_r <= PCNT_RST;
      ss_r <= 1'b0;
      pp_r <= 1'b0;
      ready_r <= 1'b1;
      energy_r <= ENERGY_RST;
      src_r <= SRC_RST;
      div_r <= DIV_RST;
      rdata_r <= '0;
      err_r <= 1'b0;
      sign_r <= 1'b0;
      busy_r <= 1'b0;
      st_r <= RBC_AWAKE;
      pre_r <= '0;
      dcnt_r <= '0;
      wcnt_r <= '0;
      osc_rdy_r <= 1'b1;
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
    end else begin
      wake_count_r <= wake_count_nxt;
      rf_reset_r <= rf_reset_nxt;
      dec_r <= dec_nxt;
      enc_r <= enc_nxt;
      suite1_r <= suite1_nxt;
      suite2_r <= suite2_nxt;
      turbo_r <= turbo_nxt;
      invert_r <= invert_nxt;
      mode_r <= mode_nxt;
      acst_r <= acst_nxt;
      pval_r <= pval_nxt;
      pdet_r <= pdet_nxt;
      csl_r <= csl_nxt;
      pcnt_r <= pcnt_nxt;
      ss_r <= ss_nxt;
      pp_r <= pp_nxt;
      ready_r <= ready_nxt;
      energy_r <= energy_nxt;
      src_r <= src_nxt;
      div_r <= div_nxt;
      rdata_r <= rdata_nxt;
      err_r <= err_nxt;
      sign_r <= sign_nxt;
      busy_r <= busy_nxt;
      st_r <= st_nxt;
      pre_r <= pre_nxt;
      dcnt_r <= dcnt_nxt;
      wcnt_r <= wcnt_nxt;
      osc_rdy_r <= osc_rdy_nxt;
      wake_s1_r <= wake_req_i;
      wake_s2_r <= wake_s1_r;
    end
  end

  // ==========================================================
  // Output drive
  assign sleep_o = (st_r == RBC_ASLEEP);
  assign osc_enable_o = (st_r != RBC_ASLEEP);
  assign osc_ready_o = osc_rdy_r;
  assign rf_fsm_reset_o = rf_reset_r;
  assign decrypt_go_o = dec_r;
  assign encrypt_go_o = enc_r;
  assign slot1_tx_suite_o = suite1_r;
  assign slot2_tx_suite_o = suite2_r;
  assign turbo_o = turbo_r;
  assign rx_sign_o = sign_r;
  assign preamble_valid_threshold_o = pval_r;
  assign preamble_detect_threshold_o = pdet_r;
  assign carrier_sense_level_o = csl_r;
  assign preamble_count_threshold_o = pcnt_r;
  assign assess_carrier_threshold_o = acst_r;
  assign channel_busy_o = busy_r;
  assign strength_start_o = ss_r;
  assign strength_per_packet_o = pp_r;

endmodule : rbc_regs

// ### testbench/rbc_regs_assertions.sv
// Concurrent checks on the ports of the baseband control register bank
module rbc_regs_assertions
  import rbc_pkg::*;
(
  input wire logic clock_i,                          // Clock
  input wire logic nrst_i,                           // Reset, active low
  input wire logic psel_i,                           // APB select
  input wire logic penable_i,                        // APB enable
  input wire logic pwrite_i,                         // APB direction
  input wire logic [11:0] paddr_i,                   // APB address
  input wire logic [31:0] pwdata_i,                  // APB write data
  input wire logic cipher_done_i,                    // Cipher finished
  input wire logic sleep_o,                          // Asleep
  input wire logic osc_enable_o,                     // Oscillator on
  input wire logic osc_ready_o,                      // Oscillator ready
  input wire logic rf_fsm_reset_o,                   // RF reset
  input wire logic decrypt_go_o,                     // Decrypt busy
  input wire logic encrypt_go_o,                     // Encrypt busy
  input wire logic [2:0] slot1_tx_suite_o,           // Slot one suite
  input wire logic [2:0] slot2_tx_suite_o,           // Slot two suite
  input wire logic [3:0] preamble_valid_threshold_o, // Preamble valid
  input wire logic [2:0] preamble_detect_threshold_o, // Preamble detect
  input wire logic strength_start_o,                 // Strength start
  input wire logic turbo_o                           // Turbo rate
);
  // ==========================================================
  // Write decode
  logic wr;
  logic [9:0] ix;
  logic ss_wr;
  assign wr = psel_i & penable_i & pwrite_i;
  assign ix = paddr_i[11:2];
  assign ss_wr = wr && ix == IDX_STRENGTH && pwdata_i[SS_BIT];
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================================
  // Properties
  rf_reset_a:
    assert property (wr && ix == IDX_RFMODE |=> rf_fsm_reset_o == $past(pwdata_i[RF_RST_BIT]))
    else $error("RF reset bit not applied");
  turbo_sel_a:
    assert property (wr && ix == IDX_RATE |=> turbo_o == $past(pwdata_i[TURBO_BIT]))
    else $error("rate select not applied");
  slot_suite_a:
    assert property (wr && ix == IDX_CIPHER |=>
      {slot2_tx_suite_o, slot1_tx_suite_o} == $past(pwdata_i[5:0]))
    else $error("suite selects not applied");
  decrypt_go_a:
    assert property (wr && ix == IDX_CIPHER && pwdata_i[DEC_BIT] |=> decrypt_go_o)
    else $error("decrypt request not raised");
  encrypt_go_a:
    assert property (wr && ix == IDX_CIPHER && pwdata_i[ENC_BIT] |=> encrypt_go_o)
    else $error("encrypt request not raised");
  go_clear_a:
    assert property ($fell(decrypt_go_o) || $fell(encrypt_go_o) |-> $past(cipher_done_i))
    else $error("cipher request dropped without done");
  start_pulse_a:
    assert property (ss_wr |=> strength_start_o ##1 !strength_start_o)
    else $error("strength start not a single pulse");
  start_cause_a:
    assert property (strength_start_o |-> $past(ss_wr))
    else $error("strength start without trigger");
  sleep_enter_a:
    assert property (wr && ix == IDX_SLEEP && pwdata_i[SLEEP_GO_BIT] && osc_ready_o |=>
      sleep_o && !osc_ready_o)
    else $error("sleep command not taken");
  osc_off_a:
    assert property (sleep_o |-> !osc_enable_o && !osc_ready_o)
    else $error("oscillator active while asleep");
  preamble_thr_a:
    assert property (wr && ix == IDX_PREAMBLE |=>
      {preamble_valid_threshold_o, preamble_detect_threshold_o} == $past(pwdata_i[7:1]))
    else $error("preamble thresholds not applied");
endmodule : rbc_regs_assertions

bind rbc_regs rbc_regs_assertions rbc_regs_assertions_i (.clock_i, .nrst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .cipher_done_i, .sleep_o, .osc_enable_o,
  .osc_ready_o, .rf_fsm_reset_o, .decrypt_go_o, .encrypt_go_o, .slot1_tx_suite_o,
  .slot2_tx_suite_o, .preamble_valid_threshold_o, .preamble_detect_threshold_o,
  .strength_start_o, .turbo_o);

// ### testbench/tb_rbc_regs.sv
// Directed APB test of the baseband control register bank
module tb_rbc_regs
  import rbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, nrst_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic wake_req_i = 1'h0, cipher_done_i = 1'h0, rx_sign_i = 1'h0;
  logic carrier_detect_i = 1'h0, strength_done_i = 1'h0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [7:0] strength_level_i = 8'h00;
  logic pready_o, pslverr_o, sleep_o, osc_enable_o, osc_ready_o, rf_fsm_reset_o, err;
  logic decrypt_go_o, encrypt_go_o, turbo_o, rx_sign_o, channel_busy_o;
  logic strength_start_o, strength_per_packet_o;
  logic [2:0] slot1_tx_suite_o, slot2_tx_suite_o, preamble_detect_threshold_o;
  logic [2:0] carrier_sense_level_o, preamble_count_threshold_o;
  logic [3:0] preamble_valid_threshold_o, assess_carrier_threshold_o;
  int n_fail = 0, checked = 0;
  logic [9:0] ixs [10] = '{IDX_SLEEP, IDX_RFMODE, IDX_CIPHER, IDX_RATE, IDX_POLAR,
    IDX_ASSESS, IDX_PREAMBLE, IDX_CSENSE, IDX_STRENGTH, IDX_ENERGY};
  logic [7:0] rstv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h48, 8'hD8, 8'h9C, 8'h01,
    8'h00};
  logic [7:0] wv [10] = '{8'h05, 8'h18, 8'h2A, 8'h01, 8'h04, 8'hB8, 8'h36, 8'h48, 8'h40,
    8'h60};
  // Mode, carrier, busy expected, level
  logic [11:0] cca [8] = '{12'h961, 12'hA60, 12'h700, 12'h4FF, 12'hF61, 12'hE60, 12'hCFF,
    12'h2FF};

  rbc_regs rbc_regs_i (.clock_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .wake_req_i, .sleep_o, .osc_enable_o,
    .osc_ready_o, .rf_fsm_reset_o, .decrypt_go_o, .encrypt_go_o, .cipher_done_i,
    .slot1_tx_suite_o, .slot2_tx_suite_o, .turbo_o, .rx_sign_i, .rx_sign_o,
    .preamble_valid_threshold_o, .preamble_detect_threshold_o, .carrier_sense_level_o,
    .preamble_count_threshold_o, .assess_carrier_threshold_o, .carrier_detect_i,
    .strength_level_i, .channel_busy_o, .strength_start_o, .strength_done_i,
    .strength_per_packet_o);

  // ==========================================================
  // Tasks
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic cyc(input int c);
    repeat (c) @(posedge clock_i);
  endtask : cyc

  task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
    int k;
    @(posedge clock_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= {ix, 2'h0};
    pwdata_i <= {24'h000000, d};
    @(posedge clock_i);
    penable_i <= 1'h1;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (pready_o !== 1'h1 && k < 20);
    if (k == 20) n_fail++;
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask : apb

  task automatic nap(input logic [7:0] src, input logic [7:0] dv, input logic [6:0] wc,
    input int lo, input int hi);
    int k;
    apb(1'h1, IDX_TICKSRC, src);
    apb(1'h1, IDX_TICKDIV, dv);
    apb(1'h1, IDX_SLEEP, {1'h0, wc});
    apb(1'h1, IDX_SLEEP, {1'h1, wc});
    @(negedge clock_i);
    check({sleep_o, osc_enable_o, osc_ready_o}, 3'h4);
    apb(1'h0, IDX_SLEEP, 8'h00);
    check(rd, {1'h0, wc});
    wake_req_i <= 1'h1;
    k = 0;
    do begin
      @(negedge clock_i);
      k++;
    end while (osc_ready_o !== 1'h1 && k < 30000);
    check(k >= lo && k <= hi, 1'h1);
    check({sleep_o, osc_enable_o}, 2'h1);
    @(posedge clock_i);
    wake_req_i <= 1'h0;
  endtask : nap

  // ==========================================================
  // Clock, watchdog and tests
  initial begin
    clock_i = 1'h0;
    forever #4 clock_i = ~clock_i;
  end

  initial begin
    #640000;
    n_fail++;
    conclude();
  end

  initial begin
    cyc(6);
    nrst_i <= 1'h1;
    @(negedge clock_i);
    check({sleep_o, osc_enable_o, osc_ready_o, turbo_o}, 4'h6);
    check({preamble_valid_threshold_o, preamble_detect_threshold_o, carrier_sense_level_o,
      preamble_count_threshold_o, assess_carrier_threshold_o}, 17'h1B272);
    for (int i = 0; i < 10; i++) begin
      apb(1'h0, ixs[i], 8'h00);
      check(rd, {24'h0, rstv[i]});
      apb(1'h1, ixs[i], wv[i]);
      apb(1'h0, ixs[i], 8'h00);
      check(rd, (i == 8) ? 32'h41 : {24'h0, wv[i]});
    end
    @(negedge clock_i);
    check({turbo_o, strength_per_packet_o}, 2'h3);
    check({preamble_valid_threshold_o, preamble_detect_threshold_o, carrier_sense_level_o,
      preamble_count_threshold_o, assess_carrier_threshold_o}, 17'h06D2E);
    apb(1'h0, 10'h100, 8'h00);
    check({err, rd}, 33'h100000000);
    for (int i = 0; i < 8; i++) begin
      apb(1'h1, IDX_CIPHER, 8'({3'(i), 3'(7 - i)}));
      @(negedge clock_i);
      check({slot2_tx_suite_o, slot1_tx_suite_o}, {3'(i), 3'(7 - i)});
    end
    apb(1'h1, IDX_RFMODE, 8'h04);
    @(negedge clock_i);
    check(rf_fsm_reset_o, 1'h1);
    apb(1'h1, IDX_RFMODE, 8'h00);
    @(negedge clock_i);
    check(rf_fsm_reset_o, 1'h0);
    cyc(24000);
    apb(1'h1, IDX_CIPHER, 8'hC0);
    apb(1'h0, IDX_CIPHER, 8'h00);
    check({rd[7:6], decrypt_go_o, encrypt_go_o}, 4'hF);
    cipher_done_i <= 1'h1;
    @(posedge clock_i);
    cipher_done_i <= 1'h0;
    @(negedge clock_i);
    check({decrypt_go_o, encrypt_go_o}, 2'h0);
    apb(1'h1, IDX_STRENGTH, 8'hC0);
    @(negedge clock_i);
    check(strength_start_o, 1'h1);
    apb(1'h0, IDX_STRENGTH, 8'h00);
    check(rd, 32'h40);
    strength_done_i <= 1'h1;
    @(posedge clock_i);
    strength_done_i <= 1'h0;
    apb(1'h0, IDX_STRENGTH, 8'h00);
    check(rd, 32'h41);
    apb(1'h1, IDX_STRENGTH, 8'h00);
    rx_sign_i <= 1'h1;
    cyc(2);
    @(negedge clock_i);
    check({strength_per_packet_o, rx_sign_o}, 2'h0);
    apb(1'h1, IDX_POLAR, 8'h00);
    cyc(2);
    @(negedge clock_i);
    check(rx_sign_o, 1'h1);
    for (int i = 0; i < 8; i++) begin
      apb(1'h1, IDX_ASSESS, {cca[i][11:10], 6'h38});
      carrier_detect_i <= cca[i][9];
      strength_level_i <= cca[i][7:0];
      cyc(2);
      @(negedge clock_i);
      check(channel_busy_o, cca[i][8]);
    end
    nap(8'h80, 8'h00, 7'h03, 2500, 3758);
    nap(8'h40, 8'h01, 7'h03, 15624, 23444);
    conclude();
  end
endmodule : tb_rbc_regs
